//--- core/ir_timer_pkg.sv
package ir_timer_pkg;

	// Register indices; byte address is four times the index
	localparam int COMMON_INDEX = 1;
	localparam int WORD_INDEX = 2;
	localparam logic [7:0] COMMON_ADDR = 8'(COMMON_INDEX * 4);
	localparam logic [7:0] WORD_ADDR = 8'(WORD_INDEX * 4);

	// Reset values
	localparam logic [7:0] COMMON_RESET = 8'h00;
	localparam logic [7:0] WORD_RESET = 8'h00;

	// Output combiner codes
	localparam logic [1:0] LOGIC_AND = 2'h0;
	localparam logic [1:0] LOGIC_OR = 2'h1;
	localparam logic [1:0] LOGIC_NOR = 2'h2;
	localparam logic [1:0] LOGIC_NAND = 2'h3;

	// Edge select codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// Transmit submodes
	localparam logic [1:0] SUB_NORMAL = 2'h0;
	localparam logic [1:0] SUB_PING_PONG = 2'h1;
	localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
	localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;

	// Glitch filter codes and widths in system clocks
	localparam logic [1:0] FILTER_NONE = 2'h0;
	localparam logic [1:0] FILTER_SHORT = 2'h1;
	localparam logic [1:0] FILTER_LONG = 2'h2;
	localparam logic [3:0] FILTER_SHORT_CLOCKS = 4'h4;
	localparam logic [3:0] FILTER_LONG_CLOCKS = 4'h8;
	localparam logic [3:0] FILTER_NONE_CLOCKS = 4'h1;

	typedef struct packed {
		logic demod_mode;
		logic pin_select;
		logic [1:0] logic_edge;
		logic [1:0] submode_filter;
		logic init_byte_rise;
		logic init_word_fall;
	} common_control_type;

	typedef struct packed {
		logic run;
		logic single_pass;
		logic timeout;
		logic [1:0] prescale;
		logic capture_mask;
		logic timeout_mask;
		logic pin_route;
	} word_control_type;

	typedef enum logic [2:0] {
		PP_IDLE = 3'b001,
		PP_BYTE = 3'b010,
		PP_WORD = 3'b100
	} ping_pong_state_type;

endpackage

//--- core/input_filter.sv
`timescale 1ns/1ps
`default_nettype none

module input_filter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic raw_input,
	input wire logic [1:0] filter_select,
	output logic rise_pulse,
	output logic fall_pulse
);

	logic sync1;
	logic sync2;
	logic sync3;
	logic level;
	logic [3:0] count;
	logic [3:0] threshold;

	// Three-stage synchroniser
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end
		else
		begin
			sync1 <= raw_input;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_comb
	begin
		case (filter_select)
			ir_timer_pkg::FILTER_SHORT: threshold = ir_timer_pkg::FILTER_SHORT_CLOCKS;
			ir_timer_pkg::FILTER_LONG: threshold = ir_timer_pkg::FILTER_LONG_CLOCKS;
			default: threshold = ir_timer_pkg::FILTER_NONE_CLOCKS;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			level <= 1'b0;
			count <= 4'h0;
			rise_pulse <= 1'b0;
			fall_pulse <= 1'b0;
		end
		else
		begin
			rise_pulse <= 1'b0;
			fall_pulse <= 1'b0;
			if (sync2 != sync3 || sync3 == level)
				count <= 4'h0;
			else if (count + 4'h2 >= threshold)
			begin
				level <= sync3;
				count <= 4'h0;
				rise_pulse <= sync3;
				fall_pulse <= ~sync3;
			end
			else
				count <= count + 4'h1;
		end
	end

endmodule // input_filter

`default_nettype wire

//--- core/ir_timer_ctrl.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ir_timer_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic stop_recovery,
	input wire logic first_demod_input_pin,
	input wire logic alternate_demod_input_pin,
	input wire logic byte_timer_running,
	input wire logic byte_timer_terminal,
	input wire logic word_timer_terminal,
	input wire logic combined_port_data,
	input wire logic word_port_data,
	output logic word_timer_run,
	output logic word_timer_count_tick,
	output logic word_timer_single_pass,
	output logic byte_timer_start,
	output logic byte_timer_output,
	output logic word_timer_output,
	output logic combined_output_pin,
	output logic word_timer_output_pin,
	output logic capture_event,
	output logic external_pin_capture,
	output logic timeout_interrupt_request,
	output logic capture_interrupt_request
);

	ir_timer_pkg::common_control_type common;
	ir_timer_pkg::word_control_type word;
	ir_timer_pkg::ping_pong_state_type pp_state;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] acc_addr;
	logic addr_phase;
	logic wr_common;
	logic wr_word;
	logic [7:0] wd;
	logic demod;
	logic run_d;
	logic byte_run_d;
	logic [2:0] prescale_count;
	logic rise_pulse;
	logic fall_pulse;
	logic rise_hit;
	logic fall_hit;
	logic edge_hit;
	logic first_seen;
	logic pp_byte_done;
	logic pp_word_done;
	logic single_stop;
	logic combined;

	// Prescaler mask for divide by 1, 2, 4 or 8
	function automatic logic [2:0] div_mask(input logic [1:0] code);
		case (code)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] addr,
		input ir_timer_pkg::common_control_type c, input ir_timer_pkg::word_control_type w);
		if (addr == ir_timer_pkg::COMMON_ADDR)
			read_reg = c;
		else if (addr == ir_timer_pkg::WORD_ADDR)
			read_reg = w;
		else
			read_reg = 8'h00;
	endfunction

	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_common = wr_pend && acc_addr == ir_timer_pkg::COMMON_ADDR;
	assign wr_word = wr_pend && acc_addr == ir_timer_pkg::WORD_ADDR;
	assign wd = hwdata[7:0];
	assign demod = common.demod_mode;
	assign hresp = 1'b0;
	assign hreadyout = ~rd_pend;

	// Bus address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_addr <= 8'h00;
		end
		else
		begin
			if (hreadyout)
			begin
				wr_pend <= addr_phase & hwrite;
				rd_pend <= addr_phase & ~hwrite;
				if (addr_phase)
					acc_addr <= {haddr[7:2], 2'b00};
			end
			else
			begin
				wr_pend <= 1'b0;
				rd_pend <= 1'b0;
			end
		end
	end

	// Read data, one wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_pend)
			hrdata <= {24'h000000, read_reg(acc_addr, common, word)};
	end

	// Common control register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			common <= ir_timer_pkg::COMMON_RESET;
		else
		begin
			if (stop_recovery)
			begin
				common.demod_mode <= 1'b0;
				common.pin_select <= 1'b0;
				common.submode_filter <= 2'h0;
			end
			else if (wr_common)
			begin
				common.demod_mode <= wd[7];
				common.pin_select <= wd[6];
				common.logic_edge <= wd[5:4];
				common.submode_filter <= wd[3:2];
			end
			if (stop_recovery)
			begin
				common.init_byte_rise <= 1'b0;
				common.init_word_fall <= 1'b0;
			end
			else if (demod)
			begin
				if (rise_hit)
					common.init_byte_rise <= 1'b1;
				else if (wr_common && wd[1])
					common.init_byte_rise <= 1'b0;
				if (fall_hit)
					common.init_word_fall <= 1'b1;
				else if (wr_common && wd[0])
					common.init_word_fall <= 1'b0;
			end
			else if (wr_common)
			begin
				common.init_byte_rise <= wd[1];
				common.init_word_fall <= wd[0];
			end
		end
	end

	assign pp_word_done = pp_state == ir_timer_pkg::PP_WORD && word_timer_terminal;
	assign pp_byte_done = pp_state == ir_timer_pkg::PP_BYTE && byte_timer_terminal;
	assign single_stop = ~demod & word.single_pass & word.run & word_timer_terminal;

	// Word timer control register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			word <= ir_timer_pkg::WORD_RESET;
		else
		begin
			if (stop_recovery)
				word.run <= 1'b0;
			else if (wr_word)
				word.run <= wd[7];
			else if (single_stop || pp_word_done)
				word.run <= 1'b0;
			else if (pp_byte_done)
				word.run <= 1'b1;
			if (stop_recovery)
			begin
				word.single_pass <= 1'b0;
				word.timeout_mask <= 1'b0;
				word.pin_route <= 1'b0;
			end
			else if (wr_word)
			begin
				word.single_pass <= wd[6];
				word.prescale <= wd[4:3];
				word.capture_mask <= wd[2];
				word.timeout_mask <= wd[1];
				word.pin_route <= wd[0];
			end
			if (word.run && word_timer_terminal)
				word.timeout <= 1'b1;
			else if (wr_word && wd[5])
				word.timeout <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pp_state <= ir_timer_pkg::PP_IDLE;
		else if (demod || common.submode_filter != ir_timer_pkg::SUB_PING_PONG)
			pp_state <= ir_timer_pkg::PP_IDLE;
		else
		begin
			case (pp_state)
				ir_timer_pkg::PP_IDLE:
					if (word.run)
						pp_state <= ir_timer_pkg::PP_WORD;
				ir_timer_pkg::PP_WORD:
					if (word_timer_terminal)
						pp_state <= ir_timer_pkg::PP_BYTE;
					else if (!word.run)
						pp_state <= ir_timer_pkg::PP_IDLE;
				ir_timer_pkg::PP_BYTE:
					if (byte_timer_terminal)
						pp_state <= ir_timer_pkg::PP_WORD;
				default:
					pp_state <= ir_timer_pkg::PP_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prescale_count <= 3'h0;
			word_timer_count_tick <= 1'b0;
		end
		else if (!word.run)
		begin
			prescale_count <= 3'h0;
			word_timer_count_tick <= 1'b0;
		end
		else
		begin
			prescale_count <= prescale_count + 3'h1;
			word_timer_count_tick <= (prescale_count & div_mask(word.prescale)) == 3'h0;
		end
	end

	// Timer output levels
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_d <= 1'b0;
			byte_run_d <= 1'b0;
			word_timer_output <= 1'b1;
			byte_timer_output <= 1'b1;
		end
		else
		begin
			run_d <= word.run;
			byte_run_d <= byte_timer_running;
			if (!demod && common.submode_filter == ir_timer_pkg::SUB_FORCE_LOW)
				word_timer_output <= 1'b0;
			else if (!demod && common.submode_filter == ir_timer_pkg::SUB_FORCE_HIGH)
				word_timer_output <= 1'b1;
			else if (!word.run)
				word_timer_output <= ~common.init_word_fall;
			else if (!run_d)
				word_timer_output <= common.init_word_fall;
			else if (word_timer_terminal)
				word_timer_output <= ~word_timer_output;
			if (!byte_timer_running)
				byte_timer_output <= ~common.init_byte_rise;
			else if (!byte_run_d)
				byte_timer_output <= common.init_byte_rise;
			else if (byte_timer_terminal)
				byte_timer_output <= ~byte_timer_output;
		end
	end

	always_comb
	begin
		case (common.logic_edge)
			ir_timer_pkg::LOGIC_AND: combined = byte_timer_output & word_timer_output;
			ir_timer_pkg::LOGIC_OR: combined = byte_timer_output | word_timer_output;
			ir_timer_pkg::LOGIC_NOR: combined = ~(byte_timer_output | word_timer_output);
			default: combined = ~(byte_timer_output & word_timer_output);
		endcase
	end

	// Pin drivers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			combined_output_pin <= 1'b0;
			word_timer_output_pin <= 1'b0;
		end
		else
		begin
			combined_output_pin <= (!demod && common.pin_select) ? combined : combined_port_data;
			word_timer_output_pin <= word.pin_route ? word_timer_output : word_port_data;
		end
	end

	input_filter demod_filter (
		.hclk(hclk),
		.hresetn(hresetn),
		.raw_input(common.pin_select ? alternate_demod_input_pin : first_demod_input_pin),
		.filter_select(common.submode_filter),
		.rise_pulse(rise_pulse),
		.fall_pulse(fall_pulse)
	);

	// Edge select, reserved code detects none
	assign rise_hit = demod & rise_pulse & (common.logic_edge == ir_timer_pkg::EDGE_RISE ||
		common.logic_edge == ir_timer_pkg::EDGE_BOTH);
	assign fall_hit = demod & fall_pulse & (common.logic_edge == ir_timer_pkg::EDGE_FALL ||
		common.logic_edge == ir_timer_pkg::EDGE_BOTH);
	assign edge_hit = (rise_hit | fall_hit) & word.run & ~(word.single_pass & first_seen);

	// Capture events and interrupt requests
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			first_seen <= 1'b0;
			capture_event <= 1'b0;
			external_pin_capture <= 1'b0;
			timeout_interrupt_request <= 1'b0;
			capture_interrupt_request <= 1'b0;
			byte_timer_start <= 1'b0;
		end
		else
		begin
			if (!word.run)
				first_seen <= 1'b0;
			else if (edge_hit)
				first_seen <= 1'b1;
			capture_event <= edge_hit;
			// First pin capture also seen externally
			external_pin_capture <= edge_hit & ~common.pin_select;
			capture_interrupt_request <= edge_hit & word.capture_mask;
			timeout_interrupt_request <= word.run & word_timer_terminal & word.timeout_mask;
			byte_timer_start <= pp_word_done;
		end
	end

	assign word_timer_run = word.run;
	assign word_timer_single_pass = word.single_pass;

endmodule // ir_timer_ctrl

`default_nettype wire

//--- tb/ir_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module ir_far_side (
	input wire logic hclk,
	input wire logic word_timer_run,
	input wire logic word_timer_count_tick,
	input wire logic byte_timer_start,
	input wire logic edge_req,
	output logic first_demod_input_pin,
	output logic alternate_demod_input_pin,
	output logic word_timer_terminal,
	output logic byte_timer_terminal,
	output logic byte_timer_running
);
	logic [2:0] ticks = 3'h0;
	logic [1:0] left = 2'h0;

	initial
	begin
		word_timer_terminal = 1'h0;
		byte_timer_terminal = 1'h0;
		first_demod_input_pin = 1'h0;
	end

	// Idle pin pulled up
	assign alternate_demod_input_pin = 1'h1;
	assign byte_timer_running = left != 2'h0;

	// Word count ends every five ticks
	always @(posedge hclk)
	begin
		word_timer_terminal <= word_timer_run && word_timer_count_tick && ticks == 3'h4;
		if (!word_timer_run || (word_timer_count_tick && ticks == 3'h4))
			ticks <= 3'h0;
		else if (word_timer_count_tick)
			ticks <= ticks + 3'h1;
	end

	// Byte count lasts three cycles
	always @(posedge hclk)
	begin
		byte_timer_terminal <= left == 2'h1;
		if (byte_timer_start)
			left <= 2'h3;
		else if (left != 2'h0)
			left <= left - 2'h1;
	end

	always @(posedge hclk)
		first_demod_input_pin <= edge_req;
endmodule // ir_far_side

`default_nettype wire

//--- tb/ir_timer_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module ir_timer_ctrl_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic word_timer_run,
	input wire logic word_timer_count_tick,
	input wire logic word_timer_terminal,
	input wire logic byte_timer_start,
	input wire logic capture_event,
	input wire logic external_pin_capture,
	input wire logic timeout_interrupt_request,
	input wire logic capture_interrupt_request
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic take;
	assign take = hsel && htrans[1] && hready && hreadyout;

	chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_resp_okay: assert property (!hresp)
		else $error("error response");
	chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_tick_run: assert property (
		word_timer_count_tick |-> $past(word_timer_run))
		else $error("tick while stopped");
	chk_timeout_irq: assert property (
		timeout_interrupt_request |-> $past(word_timer_terminal) || $past(word_timer_terminal, 2))
		else $error("timeout request without terminal");
	chk_byte_start: assert property (
		byte_timer_start |-> $past(word_timer_terminal))
		else $error("byte start without word terminal");
	chk_ext_capture: assert property (
		external_pin_capture |-> capture_event || $past(capture_event))
		else $error("external capture without capture");
	chk_cap_irq: assert property (
		capture_interrupt_request |-> capture_event)
		else $error("capture request without capture");

	cover property (take && !hwrite);
	cover property (byte_timer_start);
	cover property (capture_interrupt_request);
endmodule // ir_timer_ctrl_asserts

bind ir_timer_ctrl ir_timer_ctrl_asserts chk_u (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.word_timer_run, .word_timer_count_tick, .word_timer_terminal, .byte_timer_start,
	.capture_event, .external_pin_capture, .timeout_interrupt_request,
	.capture_interrupt_request
);

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam logic [7:0] ca = ir_timer_pkg::COMMON_ADDR;
	localparam logic [7:0] wa = ir_timer_pkg::WORD_ADDR;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, edge_req = 1'h0;
	logic stop_recovery = 1'h0, combined_port_data = 1'h0, word_port_data = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h69D0;
	logic [31:0] hrdata, obs, exp_v;
	logic hreadyout, hresp, first_demod_input_pin, alternate_demod_input_pin;
	logic word_timer_terminal, byte_timer_terminal, byte_timer_running, word_timer_run;
	logic word_timer_count_tick, word_timer_single_pass, byte_timer_start, byte_timer_output;
	logic word_timer_output, combined_output_pin, word_timer_output_pin, capture_event;
	logic external_pin_capture, timeout_interrupt_request, capture_interrupt_request;
	logic [31:0] q[$];
	int error_cnt = 0, check_count = 0, bs_cnt = 0, n;
	event seen;

	ir_timer_ctrl dut_u (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .stop_recovery, .first_demod_input_pin,
		.alternate_demod_input_pin, .byte_timer_running, .byte_timer_terminal,
		.word_timer_terminal, .combined_port_data, .word_port_data, .word_timer_run,
		.word_timer_count_tick, .word_timer_single_pass, .byte_timer_start, .byte_timer_output,
		.word_timer_output, .combined_output_pin, .word_timer_output_pin, .capture_event,
		.external_pin_capture, .timeout_interrupt_request, .capture_interrupt_request
	);

	ir_far_side far_u (
		.hclk, .word_timer_run, .word_timer_count_tick, .byte_timer_start, .edge_req,
		.first_demod_input_pin, .alternate_demod_input_pin, .word_timer_terminal,
		.byte_timer_terminal, .byte_timer_running
	);

	always #5 hclk = ~hclk;

	always @(posedge hclk)
		if (byte_timer_start === 1'h1)
			bs_cnt++;

	always @(seen)
	begin
		exp_v = q.pop_front();
		check_count++;
		if (obs !== exp_v)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: expected %h got %h", $time, exp_v, obs);
		end
	end

	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function logic gate(input logic [1:0] c, input logic a, input logic b);
		case (c)
			2'h0: return a & b;
			2'h1: return a | b;
			2'h2: return ~(a | b);
			default: return ~(a & b);
		endcase
	endfunction

	task chk(input logic [31:0] e, input logic [31:0] g);
		q.push_back(e);
		obs = g;
		-> seen;
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		obs = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(e, obs);
	endtask

	task pulse(input int len);
		edge_req <= 1'h1;
		repeat (len) @(posedge hclk);
		edge_req <= 1'h0;
		repeat (16) @(posedge hclk);
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		wrap_up;
	end

	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(ca, 32'h0);
		rd(wa, 32'h0);
		wr(8'h0C, 32'hFF);
		rd(8'h0C, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			wr(ca, {24'h0, 2'h1, i[3:2], 2'h0, i[1:0]});
			wr(wa, 32'h1);
			repeat (3) @(posedge hclk);
			chk({28'h0, gate(i[3:2], !i[1], !i[0]), !i[0], !i[1], !i[0]},
				{28'h0, combined_output_pin, word_timer_output_pin, byte_timer_output, word_timer_output});
		end
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			combined_port_data <= seed[0];
			word_port_data <= seed[1];
			wr(ca, {28'h0, 1'h1, i[1], 1'h0, i[0]});
			wr(wa, {31'h0, seed[2]});
			repeat (3) @(posedge hclk);
			chk({29'h0, seed[0], seed[2] ? i[1] : seed[1], i[1]},
				{29'h0, combined_output_pin, word_timer_output_pin, word_timer_output});
		end
		wr(ca, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(wa, {24'h0, 3'h4, i[1:0], 3'h2});
			repeat (4) @(posedge hclk);
			n = 0;
			repeat (64)
			begin
				@(posedge hclk);
				n += word_timer_count_tick;
			end
			chk(32'h40 >> i, n);
		end
		rd(wa, 32'hBA);
		wr(wa, 32'h1A);
		rd(wa, 32'h3A);
		wr(wa, 32'h20);
		rd(wa, 32'h0);
		wr(wa, 32'hC0);
		repeat (40) @(posedge hclk);
		rd(wa, 32'h60);
		wr(ca, 32'h4);
		wr(wa, 32'h80);
		repeat (40) @(posedge hclk);
		chk(32'h1, {31'h0, bs_cnt > 1});
		wr(ca, 32'h0);
		repeat (3) @(posedge hclk);
		n = bs_cnt;
		repeat (40) @(posedge hclk);
		chk(n, bs_cnt);
		wr(wa, 32'h84);
		wr(ca, 32'h80);
		for (int c = 0; c < 4; c++)
		begin
			wr(ca, {24'h0, 2'h2, c[1:0], 4'h3});
			pulse(12);
			rd(ca, {24'h0, 2'h2, c[1:0], 2'h0, c == 1 || c == 2, c == 0 || c == 2});
		end
		wr(ca, 32'hA3);
		pulse(12);
		rd(ca, 32'hA3);
		wr(ca, 32'hA1);
		rd(ca, 32'hA2);
		wr(ca, 32'hA2);
		rd(ca, 32'hA0);
		wr(ca, 32'hA4);
		pulse(2);
		rd(ca, 32'hA4);
		wr(ca, 32'hA8);
		pulse(6);
		rd(ca, 32'hA8);
		pulse(12);
		rd(ca, 32'hAB);
		wr(ca, 32'hE3);
		repeat (8) @(posedge hclk);
		wr(ca, 32'hE3);
		pulse(12);
		rd(ca, 32'hE0);
		wr(wa, 32'h4);
		wr(ca, 32'h0);
		wr(ca, 32'h3F);
		rd(ca, 32'h3F);
		wr(wa, 32'h1F);
		stop_recovery <= 1'h1;
		@(posedge hclk);
		stop_recovery <= 1'h0;
		@(posedge hclk);
		rd(ca, 32'h30);
		rd(wa, 32'h3C);
		@(posedge hclk);
		wrap_up;
	end
endmodule // tb_top

`default_nettype wire
